// ===== core/ttc_core.v
// Thermal throttle controller: clock modulation, operating point
// limiting, hot alert and catastrophic trip, with Avalon-MM registers.
// Assumes temperature comparator pins from analog sensing outside,
// and a platform that removes core supply once the trip pin falls.
//
// Operation
// - Fixed trip point from a pin; no register configures or reads it.
// - Snooping continues; interrupts latched, released only while clocks run.
// - Automatic mode overrides on-demand when hot.
// - Config register selects modulation or operating-point sub-mode.
// - Automatic activation only when die reaches maximum temperature.
// - Hot moves to thermal point; cool returns to last request.
// - Higher load request during episode is deferred until it ends.
// - Lower load request during episode applies at once.
// - Automatic modulation uses a fixed 50 percent duty.
// - Modulation stops and unit deactivates when cool again.
// - Hysteresis hold prevents rapid on/off toggling.
// - Control bit 4 activates unit immediately regardless of heat.
// - Hot alert low while die above trip point.
// - Hot alert never newly asserted in clock-stopped low power.
// - Alert held through low power until exit and cool.
// - Catastrophic trip shuts down at 125 C, any mode.
// - Catastrophic trip independent of activity, no bus cycles.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
`include "ttc_defines.vh"

module ttc_core #(
   parameter SLOT_CYC = `TTC_SLOT_CYC,
   parameter HYST_CYC = `TTC_HYST_CYC
) (
   input wire ref_clk, // 50 MHz core clock
   input wire nrst, // Async reset, active low
   input wire [3:0] avs_address, // Word address
   input wire avs_read, // Read strobe
   input wire avs_write, // Write strobe
   input wire [31:0] avs_writedata, // Write data
   input wire [3:0] avs_byteenable, // Byte lanes
   output reg [31:0] avs_readdata, // Read data
   output reg avs_waitrequest, // Stall, high until answer
   input wire die_hot, // Pin: die over trip point
   input wire die_critical, // Pin: die at about 125 C
   input wire low_power, // Pin: clocks-stopped sleep state
   input wire irq_req, // Pin: interrupt request level
   output reg core_clk_en, // Core clock gate, high = run
   output reg irq_deliver, // Latched interrupt to core
   output reg [7:0] op_point, // Applied operating point
   output reg throttle_active, // Unit active
   output reg hot_alert_n, // Hot alert, active low
   output reg catastrophic_trip_n // Catastrophic trip, active low
);

   // Counter end points, cut to the counter widths on purpose;
   // slots above 16 cycles or holds above 256 cycles do not fit
   localparam integer SLOT_M1 = SLOT_CYC - 1;
   localparam integer HYST_M1 = HYST_CYC - 1;
   localparam [3:0] SLOT_MAX = SLOT_M1[3:0];
   localparam [7:0] HYST_MAX = HYST_M1[7:0];

   // Bus handshake states
   localparam [1:0] BS_IDLE = 2'b00;
   localparam [1:0] BS_ACK = 2'b01;
   localparam [1:0] BS_DONE = 2'b10;

   // Synchronised pin levels
   wire [3:0] pins_s;
   wire hot_s = pins_s[0];
   wire crit_s = pins_s[1];
   wire lp_s = pins_s[2];
   wire irq_s = pins_s[3];

   // Software registers and internal state
   reg [4:0] ctrl_q;
   reg [15:0] cfg_q;
   reg [7:0] opreq_q;
   reg [1:0] bs_q;
   reg [3:0] slot_q;
   reg [2:0] phase_q;
   reg [7:0] hyst_q;
   reg auto_hot_q;
   reg irq_pend_q;
   reg [31:0] rd_d;
   reg [15:0] hist_q;
   reg act_prev_q;

   // Merge bytes of a write into a 32-bit value
   function [31:0] ttc_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] be;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            ttc_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8]
                                        : old_v[i*8 +: 8];
      end
   endfunction

   // Lower of two operating points
   function [7:0] ttc_min;
      input [7:0] a;
      input [7:0] b;
      begin
         ttc_min = (a < b) ? a : b;
      end
   endfunction

   // Duty in eighths: fixed half in automatic mode, else the field.
   // Zero reads as half, so that the core is never stopped for good.
   function [2:0] ttc_duty;
      input auto_mod;
      input [2:0] field;
      begin
         if (auto_mod)
            ttc_duty = `TTC_AUTO_DUTY;
         else if (field == 3'h0)
            ttc_duty = `TTC_AUTO_DUTY;
         else
            ttc_duty = field;
      end
   endfunction

   // Pins cross into the clock domain through two flops each
   ttc_sync #(
      .WIDTH(4)
   ) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in({irq_req, low_power, die_critical, die_hot}),
      .sync_q(pins_s)
   );

   // Writes land at the answer edge, where the master sees the ack
   wire bus_req = avs_read | avs_write;
   wire wr_go = avs_write && (bs_q == BS_ACK);
   wire [31:0] ctrl_w = ttc_merge({27'h0, ctrl_q}, avs_writedata,
                                  avs_byteenable);
   wire [31:0] cfg_w = ttc_merge({16'h0, cfg_q}, avs_writedata,
                                 avs_byteenable);
   wire [31:0] opr_w = ttc_merge({24'h0, opreq_q}, avs_writedata,
                                 avs_byteenable);

   // Register fields
   wire auto_en = cfg_q[`TTC_CFG_AUTO_BIT];
   wire sub_op = cfg_q[`TTC_CFG_SUBMODE_BIT];
   wire [7:0] therm_op = cfg_q[`TTC_CFG_THERM_OP_MSB:`TTC_CFG_THERM_OP_LSB];
   wire ondem = ctrl_q[`TTC_CTRL_ONDEM_BIT];
   wire [2:0] od_duty = ctrl_q[`TTC_CTRL_DUTY_MSB:`TTC_CTRL_DUTY_LSB];

   // Episode states: automatic only when enabled and hot
   wire auto_episode = auto_en && auto_hot_q;
   wire mod_auto = auto_episode && !sub_op;
   wire op_episode = auto_episode && sub_op;
   // Automatic wins; on-demand acts only when automatic is not hot
   wire mod_ondem = ondem && !auto_episode;
   wire [2:0] duty = ttc_duty(mod_auto, od_duty);
   wire modulating = mod_auto || mod_ondem;

   // Avalon slave: one wait cycle, answer on the second edge.
   // The idle cycle after each answer keeps a request that the
   // master has not yet dropped from being taken twice.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bs_q <= BS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         case (bs_q)
            BS_IDLE: begin
               if (bus_req) begin
                  bs_q <= BS_ACK;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= rd_d;
               end
            end
            BS_ACK: begin
               // Answer stands for exactly one cycle
               bs_q <= BS_DONE;
               avs_waitrequest <= 1'b1;
            end
            BS_DONE: begin
               // Master releases its request after the answer edge
               bs_q <= BS_IDLE;
            end
            default: begin
               bs_q <= BS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Read mux; the trip threshold has no register at all.
   // Status bit 7 is spare and reads as zero.
   always @* begin
      case (avs_address)
         `TTC_REG_CTRL: rd_d = {27'h0, ctrl_q};
         `TTC_REG_CFG: rd_d = {16'h0, cfg_q};
         `TTC_REG_OPREQ: rd_d = {24'h0, opreq_q};
         `TTC_REG_STATUS: rd_d = {16'h0, op_point, 1'b0, lp_s,
                                  op_episode, mod_auto, throttle_active,
                                  ~hot_alert_n, ~catastrophic_trip_n,
                                  core_clk_en};
         `TTC_REG_HIST: rd_d = {16'h0, hist_q};
         default: rd_d = `TTC_UNMAPPED;
      endcase
   end

   // Register writes, taken at the answer edge; unmapped writes
   // are ignored, and the counter clears in its own process
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `TTC_CTRL_RESET;
         cfg_q <= `TTC_CFG_RESET;
         opreq_q <= `TTC_OPREQ_RESET;
      end else if (wr_go) begin
         case (avs_address)
            `TTC_REG_CTRL: ctrl_q <= ctrl_w[4:0];
            `TTC_REG_CFG: cfg_q <= cfg_w[15:0];
            `TTC_REG_OPREQ: opreq_q <= opr_w[7:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Hysteresis: trip sets at once, clears only after a cool hold.
   // The hold restarts on every hot sample, so a pin that chatters
   // near the trip point keeps the unit steadily on.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         auto_hot_q <= 1'b0;
         hyst_q <= 8'h00;
      end else if (hot_s) begin
         auto_hot_q <= 1'b1;
         hyst_q <= HYST_MAX;
      end else if (hyst_q != 8'h00) begin
         hyst_q <= hyst_q - 8'h01;
      end else begin
         auto_hot_q <= 1'b0;
      end
   end

   // Modulation period of eight slots; clocks run for first duty slots.
   // Phase restarts at zero on each activation, so every episode
   // opens with its clocks running and the core never starts frozen.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         slot_q <= 4'h0;
         phase_q <= 3'h0;
         core_clk_en <= 1'b1;
      end else if (!modulating) begin
         slot_q <= 4'h0;
         phase_q <= 3'h0;
         core_clk_en <= 1'b1;
      end else begin
         if (slot_q == SLOT_MAX) begin
            slot_q <= 4'h0;
            phase_q <= phase_q + 3'h1;
         end else begin
            slot_q <= slot_q + 4'h1;
         end
         core_clk_en <= (phase_q < duty);
      end
   end

   // Interrupts latched, released only while clocks run.
   // A request in a stopped slot waits in the pending flag; a new
   // request in the same cycle as delivery keeps the flag set.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_pend_q <= 1'b0;
         irq_deliver <= 1'b0;
      end else begin
         irq_pend_q <= irq_s | (irq_pend_q & ~core_clk_en);
         irq_deliver <= (irq_s | irq_pend_q) & core_clk_en;
      end
   end

   // Operating point: thermal episode caps the last load request.
   // No deferral store: the last request always sits in its register.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         op_point <= `TTC_OPREQ_RESET;
      end else if (op_episode) begin
         // Lower request passes now; higher waits for episode end
         op_point <= ttc_min(opreq_q, therm_op);
      end else begin
         op_point <= opreq_q;
      end
   end

   // Unit active while modulating or in an operating point episode
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         throttle_active <= 1'b0;
      else
         throttle_active <= modulating || op_episode;
   end

   // Hot alert follows the hot pin; frozen while asleep.
   // Only an awake core may newly assert it, and only an awake,
   // cool core may release it.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         hot_alert_n <= 1'b1;
      end else if (!hot_s) begin
         if (!lp_s)
            hot_alert_n <= 1'b1;
      end else if (!lp_s) begin
         hot_alert_n <= 1'b0;
      end
   end

   // Catastrophic trip: sticky until reset, no bus involvement.
   // Kept apart from the mode logic so that no setting can mask it.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         catastrophic_trip_n <= 1'b1;
      else if (crit_s)
         catastrophic_trip_n <= 1'b0;
   end

   // Episode counter: counts each new activation and saturates.
   // A write clears it; a new episode in the same cycle wins.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         act_prev_q <= 1'b0;
         hist_q <= 16'h0000;
      end else begin
         act_prev_q <= throttle_active;
         if (throttle_active && !act_prev_q) begin
            if (hist_q != 16'hFFFF)
               hist_q <= hist_q + 16'h0001;
         end else if (wr_go && (avs_address == `TTC_REG_HIST)) begin
            hist_q <= 16'h0000;
         end
      end
   end

endmodule

`default_nettype wire

// ===== core/ttc_sync.v
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes a single clock and an active-low asynchronous reset.
`default_nettype none

module ttc_sync #(
   parameter WIDTH = 4
) (
   input wire ref_clk, // Core clock
   input wire nrst, // Async reset, active low
   input wire [WIDTH-1:0] async_in, // Raw pin levels
   output reg [WIDTH-1:0] sync_q // Synchronised levels
);

   reg [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

endmodule

`default_nettype wire

// ===== inc/ttc_defines.vh
// Constants for the thermal throttle controller: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the core files.
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH

// Avalon word addresses (byte address = 4 * index)
`define TTC_REG_CTRL 4'h0
`define TTC_REG_CFG 4'h1
`define TTC_REG_OPREQ 4'h2
`define TTC_REG_STATUS 4'h3
`define TTC_REG_HIST 4'h4

// Thermal control register fields
`define TTC_CTRL_DUTY_LSB 1
`define TTC_CTRL_DUTY_MSB 3
`define TTC_CTRL_ONDEM_BIT 4
`define TTC_CTRL_RESET 5'h00

// Model-specific configuration register fields
`define TTC_CFG_AUTO_BIT 0
`define TTC_CFG_SUBMODE_BIT 1
`define TTC_CFG_THERM_OP_LSB 8
`define TTC_CFG_THERM_OP_MSB 15
`define TTC_CFG_RESET 16'h0001

// Operating point request reset value (top point)
`define TTC_OPREQ_RESET 8'hFF

// Fixed automatic duty: 4 eighths on
`define TTC_AUTO_DUTY 3'h4

// Length of one modulation eighth, in ns, and in cycles at 50 MHz
`define TTC_SLOT_NS 160
`define TTC_CLK_NS 20
`define TTC_SLOT_CYC (`TTC_SLOT_NS / `TTC_CLK_NS)

// Hysteresis hold after the trip clears, in ns and cycles
`define TTC_HYST_NS 2000
`define TTC_HYST_CYC (`TTC_HYST_NS / `TTC_CLK_NS)

// Unmapped reads answer with this value
`define TTC_UNMAPPED 32'h00000000

`endif

// ===== test/tb.sv
// Directed bench for the throttle controller.
// Assumes ttc_core, the platform model and the bound checker.
`default_nettype none
`include "ttc_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SL = 2;
   localparam int HY = 4;
   logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic die_hot, die_critical, low_power, irq_req, supply_on;
   logic core_clk_en, irq_deliver, throttle_active, hot_alert_n, trip_n;
   logic [7:0] op_point;
   int fail_count = 0;
   int n_checks = 0;
   // Short slots and hold keep the run brief
   ttc_core #(.SLOT_CYC(SL), .HYST_CYC(HY)) i_ttc_core (
      .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .die_hot(die_hot), .die_critical(die_critical),
      .low_power(low_power), .irq_req(irq_req),
      .core_clk_en(core_clk_en), .irq_deliver(irq_deliver),
      .op_point(op_point), .throttle_active(throttle_active),
      .hot_alert_n(hot_alert_n), .catastrophic_trip_n(trip_n));
   ttc_plat i_ttc_plat (.ref_clk(ref_clk), .catastrophic_trip_n(trip_n),
      .die_hot(die_hot), .die_critical(die_critical),
      .low_power(low_power), .irq_req(irq_req), .supply_on(supply_on));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Held until waitrequest is sampled low; read data taken there
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      for (i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 40) begin
         fail_count++;
         end_sim();
      end
   endtask
   // Running slots over one full modulation period
   task automatic duty(input int n);
      int c;
      c = 0;
      repeat (8 * SL) begin
         @(posedge ref_clk);
         if (core_clk_en === 1'b1)
            c++;
      end
      chk(c, n * SL);
   endtask
   task automatic t_regs;
      bus(1'b1, 4'hF, 32'hFFFFFFFF);
      bus(1'b0, 4'hF, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `TTC_REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `TTC_REG_CFG, 32'h0);
      chk(rd, 32'h1);
      avs_byteenable <= 4'h2;
      bus(1'b1, `TTC_REG_CFG, 32'h000055FF);
      avs_byteenable <= 4'hF;
      bus(1'b0, `TTC_REG_CFG, 32'h0);
      chk(rd, 32'h5501);
      bus(1'b1, `TTC_REG_CFG, 32'h1);
      bus(1'b0, `TTC_REG_OPREQ, 32'h0);
      chk(rd, 32'hFF);
      chk(throttle_active, 1'b0);
      $display("t_regs done");
   endtask
   // Heat with both modes on, then cooling through the hold
   task automatic t_auto;
      i_ttc_plat.pins(4'h8);
      cyc(8);
      chk(throttle_active, 1'b1);
      chk(hot_alert_n, 1'b0);
      duty(4);
      bus(1'b1, `TTC_REG_CTRL, 32'h12);
      cyc(8 * SL);
      duty(4);
      bus(1'b1, `TTC_REG_CTRL, 32'h0);
      i_ttc_plat.pins(4'h0);
      cyc(HY - 1);
      chk(throttle_active, 1'b1);
      cyc(5 * HY);
      chk(throttle_active, 1'b0);
      duty(8);
      $display("t_auto done");
   endtask
   task automatic t_demand;
      int c;
      for (int n = 1; n < 8; n++) begin
         bus(1'b1, `TTC_REG_CTRL, 32'h10 | (n << 1));
         cyc(8 * SL);
         duty(n);
         chk(throttle_active, 1'b1);
      end
      i_ttc_plat.pins(4'h1);
      cyc(32 * SL);
      c = 0;
      repeat (8 * SL) begin
         @(posedge ref_clk);
         if (irq_deliver === 1'b1)
            c++;
      end
      chk(c, 7 * SL);
      bus(1'b1, `TTC_REG_CTRL, 32'h0);
      i_ttc_plat.pins(4'h0);
      cyc(8);
      chk(throttle_active, 1'b0);
      $display("t_demand done");
   endtask
   // Operating point episode with lower and higher load requests
   task automatic t_op;
      bus(1'b1, `TTC_REG_CFG, 32'h4003);
      i_ttc_plat.pins(4'h8);
      cyc(8);
      chk(op_point, 8'h40);
      duty(8);
      bus(1'b1, `TTC_REG_OPREQ, 32'h20);
      cyc(4);
      chk(op_point, 8'h20);
      bus(1'b1, `TTC_REG_OPREQ, 32'h80);
      cyc(4);
      chk(op_point, 8'h40);
      i_ttc_plat.pins(4'h0);
      cyc(6 * HY);
      chk(op_point, 8'h80);
      bus(1'b1, `TTC_REG_CFG, 32'h1);
      $display("t_op done");
   endtask
   task automatic t_sleep;
      i_ttc_plat.pins(4'h2);
      cyc(6);
      i_ttc_plat.pins(4'hA);
      cyc(8);
      chk(hot_alert_n, 1'b1);
      i_ttc_plat.pins(4'h8);
      cyc(8);
      chk(hot_alert_n, 1'b0);
      i_ttc_plat.pins(4'hA);
      cyc(6);
      i_ttc_plat.pins(4'h2);
      cyc(8);
      chk(hot_alert_n, 1'b0);
      i_ttc_plat.pins(4'h0);
      cyc(8);
      chk(hot_alert_n, 1'b1);
      $display("t_sleep done");
   endtask
   // Trip with automatic mode off; no bus answer appears
   task automatic t_trip;
      bus(1'b1, `TTC_REG_CFG, 32'h0);
      i_ttc_plat.pins(4'h4);
      cyc(6);
      chk(trip_n, 1'b0);
      chk(avs_waitrequest, 1'b1);
      cyc(8);
      chk(supply_on, 1'b0);
      bus(1'b0, `TTC_REG_HIST, 32'h0);
      chk(rd, 32'h4);
      bus(1'b1, `TTC_REG_HIST, 32'h0);
      bus(1'b0, `TTC_REG_HIST, 32'h0);
      chk(rd, 32'h0);
      $display("t_trip done");
   endtask
   initial begin
      nrst = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      cyc(12);
      nrst <= 1'b1;
      t_regs();
      t_auto();
      t_demand();
      t_op();
      t_sleep();
      t_trip();
      end_sim();
   end
endmodule
`default_nettype wire

// ===== test/ttc_core_sva.sv
// Port assertions for the throttle controller.
// Assumes one clock and the active-low async reset.
`default_nettype none
module ttc_chk #(parameter SLOT_CYC = 8, parameter HYST_CYC = 100) (
   input wire logic ref_clk, // Clock
   input wire logic nrst, // Reset
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic avs_waitrequest, // Stall
   input wire logic die_hot, // Hot pin
   input wire logic die_critical, // Trip pin
   input wire logic low_power, // Sleep pin
   input wire logic core_clk_en, // Gate
   input wire logic irq_deliver, // Irq out
   input wire logic throttle_active, // Active
   input wire logic hot_alert_n, // Alert
   input wire logic catastrophic_trip_n // Trip
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Bus: one wait cycle, answer lasts one cycle
   AST_WAIT_ONE:
      assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("No answer after one wait");
   AST_WAIT_PULSE:
      assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("Answer longer than one cycle");
   // Trip is quick and sticky, whatever the mode
   AST_TRIP_FAST:
      assert property ($rose(die_critical) |-> ##[1:4] !catastrophic_trip_n)
      else $error("Trip late");
   AST_TRIP_STICKY:
      assert property (!catastrophic_trip_n |=> !catastrophic_trip_n)
      else $error("Trip released");
   // Alert follows heat, frozen while asleep
   AST_ALERT:
      assert property ((die_hot && !low_power)[*5] |-> !hot_alert_n)
      else $error("Alert missing");
   AST_NO_NEW_ALERT:
      assert property ((low_power && hot_alert_n)[*4] |=> hot_alert_n)
      else $error("Alert raised asleep");
   AST_HOLD_LP:
      assert property ((low_power && !hot_alert_n)[*4] |=> !hot_alert_n)
      else $error("Alert dropped asleep");
   // Idle unit leaves clocks running; irq only with clocks
   AST_IDLE_RUN:
      assert property ((!throttle_active && catastrophic_trip_n)[*2]
         |-> core_clk_en) else $error("Clock stopped while idle");
   AST_IRQ_RUN:
      assert property ($rose(irq_deliver) |-> core_clk_en ||
         $past(core_clk_en)) else $error("Irq while stopped");
   COV_MOD: cover property (throttle_active && !core_clk_en);
   COV_SLEEP: cover property (low_power && !hot_alert_n);
   COV_TRIP: cover property (!catastrophic_trip_n);
endmodule
bind ttc_core ttc_chk #(.SLOT_CYC(SLOT_CYC), .HYST_CYC(HYST_CYC)) i_ttc_chk (
   .ref_clk(ref_clk), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .die_hot(die_hot), .die_critical(die_critical), .low_power(low_power),
   .core_clk_en(core_clk_en), .irq_deliver(irq_deliver),
   .throttle_active(throttle_active), .hot_alert_n(hot_alert_n),
   .catastrophic_trip_n(catastrophic_trip_n));
`default_nettype wire

// ===== test/ttc_plat.sv
// Platform model: drives sensor and sleep pins, cuts supply on trip.
// Assumes pins() is called just after a rising edge.
`default_nettype none
module ttc_plat #(parameter int SHUT_CYC = 3) (
   input wire logic ref_clk, // Clock
   input wire logic catastrophic_trip_n, // Trip in
   output logic die_hot, // Over trip point
   output logic die_critical, // Near 125 C
   output logic low_power, // Sleep state
   output logic irq_req, // Irq level
   output logic supply_on // Core supply
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial {die_hot, die_critical, low_power, irq_req, supply_on} = 5'h01;
   task automatic pins(input logic [3:0] v);
      {die_hot, die_critical, low_power, irq_req} <= v;
   endtask
   // Supply removed a few cycles after trip, never restored
   always @(posedge ref_clk)
      if (catastrophic_trip_n === 1'b0) begin
         cnt <= cnt + 1;
         if (cnt >= SHUT_CYC)
            supply_on <= 1'b0;
      end
endmodule
`default_nettype wire
